// >>> rtl/rais_pkg.sv
// Package of the reset and interrupt structure: register map, source table,
// vectors and the carrier types. Assumes one core clock and word registers.
`default_nettype none
package rais_pkg;
   localparam int NSRC = 22;
   localparam int NLINE = 6;
   localparam int AW = 4;
   localparam int DW = 16;
   localparam int VW = 6;

   // Register word addresses
   localparam logic [AW-1:0] ADDR_PEND0 = 4'h0;
   localparam logic [AW-1:0] ADDR_PEND2 = 4'h1;
   localparam logic [AW-1:0] ADDR_EN0 = 4'h2;
   localparam logic [AW-1:0] ADDR_EN2 = 4'h3;
   localparam logic [AW-1:0] ADDR_LMASK = 4'h4;
   localparam logic [AW-1:0] ADDR_GFLAG = 4'h5;
   localparam logic [AW-1:0] ADDR_PVEC = 4'h6;
   localparam logic [AW-1:0] ADDR_STAT = 4'h7;
   localparam logic [AW-1:0] ADDR_IMASK = 4'h8;

   // Values after reset
   localparam logic [NLINE-1:0] LMASK_RST = 6'h00;
   localparam logic GFLAG_RST = 1'b1;
   localparam logic [7:0] PVEC_RST = 8'h00;

   // Status bit positions
   localparam int STAT_ACK = 0;
   localparam int STAT_SPUR = 1;
   localparam int NSTAT = 2;

   // Branch vectors
   localparam logic [VW-1:0] VEC_RESET = 6'h00;
   localparam logic [VW-1:0] VEC_TRAP = 6'h22;
   localparam logic [VW-1:0] VEC_NMI = 6'h24;
   localparam logic [VW-1:0] VEC_EMU = 6'h26;

   // Source indices of the four pin driven requests
   localparam int SRC_PFA = 0;
   localparam int SRC_PFB = 1;
   localparam int SRC_X1 = 3;
   localparam int SRC_X2 = 4;

   // Source table in priority order, index 0 highest
   localparam logic SRC_GRP [NSRC] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0,
      1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
      1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
   localparam logic [3:0] SRC_BIT [NSRC] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h3,
      4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he,
      4'hf, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5};
   localparam logic [7:0] SRC_CODE [NSRC] = '{8'h20, 8'h19, 8'h04, 8'h01,
      8'h11, 8'h05, 8'h06, 8'h07, 8'h40, 8'h41, 8'h21, 8'h22, 8'h23, 8'h27,
      8'h28, 8'h29, 8'h2a, 8'h24, 8'h25, 8'h26, 8'h2f, 8'h30};
   localparam logic [2:0] SRC_LINE [NSRC] = '{3'h0, 3'h0, 3'h0, 3'h0,
      3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1,
      3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1};

   typedef struct packed {
      logic soft_interrupt_instr;
      logic nmi;
      logic trap;
      logic emu;
      logic [VW-1:0] vec;
   } rais_sw_req_t;

   typedef struct packed {
      logic valid;
      logic gdis;
      logic [VW-1:0] vec;
   } rais_branch_t;
endpackage
`default_nettype wire

// >>> rtl/rais_ctrl.sv
// Reset and interrupt structure: reset requests, pin and peripheral
// requests, line grouping with unique codes, software branch requests.
// Assumes all inputs synchronous to clk_in and one-cycle strobes.
//
// Behaviour
// [RQ1] Reset bypasses arbitration and acts at once over everything; reg_rdata_out is cleared by rst_n_in only, not by the pin or watchdog.
// [RQ2] After reset all maskable requests stay disabled until software enables.
// [RQ3] Reset comes from the reset pin or the watchdog time-out only; the code also resets on rst_n_in.
// [RQ4] Four pins raise external requests: two general, two power faults.
// [RQ5] External requests pass their own enable and the core line mask.
// [RQ6] Peripheral requests pass a per-event enable and the core line mask.
// [RQ7] Soft interrupt branches to its operand vector and sets global disable.
// [RQ8] Non-maskable instruction branches to 24h and sets global disable.
// [RQ9] No hardware non-maskable input exists; software only.
// [RQ10] Trap branches to 22h and leaves global disable unchanged.
// [RQ11] Emulator trap is reachable by soft interrupt or trap.
// [RQ12] Peripheral requests are grouped onto six shared core lines; the source table uses lines 0 and 1 only.
// [RQ13] Every peripheral source presents its own unique vector code.
// [RQ14] Reset is top priority, non-maskable, vectors to 0000h.
// [RQ15] Each source owns a fixed pending bit position and a code.
// [RQ16] Line acknowledge loads top pending enabled code, clears its pending.
//
// The address-and-strobe port and the register offsets were left to the implementer.
`default_nettype none
module rais_ctrl (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic reset_pin_n_in,
   input wire logic wdog_timeout_in,
   input wire logic ext_irq_one_in,
   input wire logic ext_irq_two_in,
   input wire logic power_fault_irq_a_in,
   input wire logic power_fault_irq_b_in,
   input wire logic [rais_pkg::NSRC-1:0] periph_req_in,
   input wire logic core_ack_in,
   input wire logic [2:0] core_ack_line_in,
   input wire rais_pkg::rais_sw_req_t sw_req_in,
   input wire logic [rais_pkg::AW-1:0] reg_addr_in,
   input wire logic [rais_pkg::DW-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [rais_pkg::DW-1:0] reg_rdata_out,
   output logic core_reset_out,
   output logic [rais_pkg::NLINE-1:0] core_int_lines_out,
   output rais_pkg::rais_branch_t branch_out,
   output logic global_int_disable_flag_out,
   output logic [7:0] periph_vector_code_out,
   output logic irq_out
);
   localparam int N = rais_pkg::NSRC;

   function automatic logic [rais_pkg::DW-1:0] pack_grp(input logic g,
                                                       input logic [N-1:0] v);
      logic [rais_pkg::DW-1:0] w;
      w = '0;
      for (int i = 0; i < N; i++) begin
         if (rais_pkg::SRC_GRP[i] == g) begin
            w[rais_pkg::SRC_BIT[i]] = v[i];
         end
      end
      return w;
   endfunction

   function automatic logic [N-1:0] unpack_grp(input logic g,
                                               input logic [rais_pkg::DW-1:0] w);
      logic [N-1:0] u;
      u = '0;
      for (int i = 0; i < N; i++) begin
         u[i] = (rais_pkg::SRC_GRP[i] == g) && w[rais_pkg::SRC_BIT[i]];
      end
      return u;
   endfunction

   function automatic logic [N-1:0] on_line(input logic [2:0] l);
      logic [N-1:0] m;
      m = '0;
      for (int i = 0; i < N; i++) begin
         m[i] = (rais_pkg::SRC_LINE[i] == l);
      end
      return m;
   endfunction

   logic rst_req;
   logic [3:0] pin_prev;
   logic [N-1:0] pend;
   logic [N-1:0] en;
   logic [N-1:0] src_evt;
   logic [N-1:0] cand;
   logic [N-1:0] ack_clr;
   logic [N-1:0] wr_clr;
   logic [N-1:0] next_pend;
   logic [rais_pkg::NLINE-1:0] lmask;
   logic gflag;
   logic [rais_pkg::NSTAT-1:0] stat;
   logic [rais_pkg::NSTAT-1:0] imask;
   logic [rais_pkg::NSTAT-1:0] stat_set;
   logic [4:0] sel;
   logic sel_valid;
   logic wr_hit_pend0;
   logic wr_hit_pend2;

   // Plain sync reset, reset pin or watchdog; held state is forced each cycle
   assign rst_req = !rst_n_in || !reset_pin_n_in || wdog_timeout_in; // [RQ3]

   always_ff @(posedge clk_in) begin
      core_reset_out <= rst_req; // [RQ1] [RQ14]
   end

   // Pins are edge requests; a level held high raises one request only
   always_ff @(posedge clk_in) begin
      if (rst_req) begin
         pin_prev <= 4'h0;
      end else begin
         pin_prev <= {ext_irq_two_in, ext_irq_one_in,
                      power_fault_irq_b_in, power_fault_irq_a_in};
      end
   end

   always_comb begin
      src_evt = periph_req_in;
      src_evt[rais_pkg::SRC_PFA] = power_fault_irq_a_in && !pin_prev[0]; // [RQ4]
      src_evt[rais_pkg::SRC_PFB] = power_fault_irq_b_in && !pin_prev[1]; // [RQ4]
      src_evt[rais_pkg::SRC_X1] = ext_irq_one_in && !pin_prev[2]; // [RQ4]
      src_evt[rais_pkg::SRC_X2] = ext_irq_two_in && !pin_prev[3]; // [RQ4]
   end

   // Acknowledge picks the lowest index, which is the highest priority
   assign cand = pend & en & on_line(core_ack_line_in);

   always_comb begin
      sel = 5'h00;
      sel_valid = 1'b0;
      for (int i = N - 1; i >= 0; i--) begin
         if (cand[i]) begin
            sel = 5'(i); // [RQ16]
            sel_valid = 1'b1;
         end
      end
   end

   assign wr_hit_pend0 = reg_wr_in && (reg_addr_in == rais_pkg::ADDR_PEND0);
   assign wr_hit_pend2 = reg_wr_in && (reg_addr_in == rais_pkg::ADDR_PEND2);

   always_comb begin
      ack_clr = '0;
      if (core_ack_in && sel_valid) begin
         ack_clr[sel] = 1'b1; // [RQ16]
      end
      wr_clr = '0;
      if (wr_hit_pend0) begin
         wr_clr = unpack_grp(1'b0, reg_wdata_in);
      end else if (wr_hit_pend2) begin
         wr_clr = unpack_grp(1'b1, reg_wdata_in);
      end
   end

   // A request landing in its clear cycle survives
   assign next_pend = (pend & ~(ack_clr | wr_clr)) | src_evt;

   always_ff @(posedge clk_in) begin
      if (rst_req) begin
         pend <= '0;
      end else begin
         pend <= next_pend; // [RQ15]
      end
   end

   // Per-source enables, external ones included, all clear after reset
   always_ff @(posedge clk_in) begin
      if (rst_req) begin
         en <= '0; // [RQ2]
      end else if (reg_wr_in && reg_addr_in == rais_pkg::ADDR_EN0) begin
         en <= (en & ~unpack_grp(1'b0, 16'hffff)) | unpack_grp(1'b0, reg_wdata_in);
      end else if (reg_wr_in && reg_addr_in == rais_pkg::ADDR_EN2) begin
         en <= (en & ~unpack_grp(1'b1, 16'hffff)) | unpack_grp(1'b1, reg_wdata_in);
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_req) begin
         lmask <= rais_pkg::LMASK_RST; // [RQ2]
      end else if (reg_wr_in && reg_addr_in == rais_pkg::ADDR_LMASK) begin
         lmask <= reg_wdata_in[rais_pkg::NLINE-1:0];
      end
   end

   // Soft interrupt, non-maskable instruction or acknowledge sets the flag, a trap does not; setting wins over a software clear
   always_ff @(posedge clk_in) begin
      if (rst_req) begin
         gflag <= rais_pkg::GFLAG_RST; // [RQ2]
      end else if (sw_req_in.soft_interrupt_instr || sw_req_in.nmi || core_ack_in) begin
         gflag <= 1'b1; // [RQ7] [RQ8]
      end else if (reg_wr_in && reg_addr_in == rais_pkg::ADDR_GFLAG) begin
         gflag <= reg_wdata_in[0];
      end
   end

   assign global_int_disable_flag_out = gflag;

   // Each line is the OR of its group, gated by enable and line mask
   generate
      for (genvar l = 0; l < rais_pkg::NLINE; l++) begin : g_line
         always_ff @(posedge clk_in) begin
            if (rst_req) begin
               core_int_lines_out[l] <= 1'b0;
            end else begin
               core_int_lines_out[l] <= lmask[l] &&
                  |(pend & en & on_line(3'(l))); // [RQ5] [RQ6] [RQ12]
            end
         end
      end
   endgenerate

   // Software branches; there is no pin path to the non-maskable vector
   always_ff @(posedge clk_in) begin
      if (rst_req) begin
         branch_out <= '{valid: 1'b1, gdis: 1'b1, vec: rais_pkg::VEC_RESET}; // [RQ14]
      end else if (sw_req_in.soft_interrupt_instr) begin
         branch_out <= '{valid: 1'b1, gdis: 1'b1, vec: sw_req_in.vec}; // [RQ7] [RQ11]
      end else if (sw_req_in.nmi) begin
         branch_out <= '{valid: 1'b1, gdis: 1'b1, vec: rais_pkg::VEC_NMI}; // [RQ8] [RQ9]
      end else if (sw_req_in.trap) begin
         branch_out <= '{valid: 1'b1, gdis: 1'b0,
                         vec: sw_req_in.emu ? rais_pkg::VEC_EMU
                                            : rais_pkg::VEC_TRAP}; // [RQ10] [RQ11]
      end else begin
         branch_out <= '{valid: 1'b0, gdis: 1'b0, vec: rais_pkg::VEC_RESET};
      end
   end

   // Code of the chosen source; an empty acknowledge reads zero
   always_ff @(posedge clk_in) begin
      if (rst_req) begin
         periph_vector_code_out <= rais_pkg::PVEC_RST;
      end else if (core_ack_in) begin
         periph_vector_code_out <= sel_valid ? rais_pkg::SRC_CODE[sel]
                                             : rais_pkg::PVEC_RST; // [RQ13] [RQ16]
      end
   end

   assign stat_set[rais_pkg::STAT_ACK] = core_ack_in && sel_valid;
   assign stat_set[rais_pkg::STAT_SPUR] = core_ack_in && !sel_valid;

   always_ff @(posedge clk_in) begin
      if (rst_req) begin
         stat <= '0;
      end else if (reg_wr_in && reg_addr_in == rais_pkg::ADDR_STAT) begin
         stat <= (stat & ~reg_wdata_in[rais_pkg::NSTAT-1:0]) | stat_set;
      end else begin
         stat <= stat | stat_set;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_req) begin
         imask <= '0;
      end else if (reg_wr_in && reg_addr_in == rais_pkg::ADDR_IMASK) begin
         imask <= reg_wdata_in[rais_pkg::NSTAT-1:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_req) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(stat & imask);
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !reg_rd_in) begin
         reg_rdata_out <= '0;
      end else begin
         unique case (reg_addr_in)
            rais_pkg::ADDR_PEND0: reg_rdata_out <= pack_grp(1'b0, pend);
            rais_pkg::ADDR_PEND2: reg_rdata_out <= pack_grp(1'b1, pend);
            rais_pkg::ADDR_EN0: reg_rdata_out <= pack_grp(1'b0, en);
            rais_pkg::ADDR_EN2: reg_rdata_out <= pack_grp(1'b1, en);
            rais_pkg::ADDR_LMASK: reg_rdata_out <= {10'h000, lmask};
            rais_pkg::ADDR_GFLAG: reg_rdata_out <= {15'h0000, gflag};
            rais_pkg::ADDR_PVEC: reg_rdata_out <= {8'h00, periph_vector_code_out};
            rais_pkg::ADDR_STAT: reg_rdata_out <= {14'h0000, stat};
            rais_pkg::ADDR_IMASK: reg_rdata_out <= {14'h0000, imask};
            default: reg_rdata_out <= '0;
         endcase
      end
   end

   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_ack_taken;
      core_ack_in && sel_valid && !rst_req;
   endsequence
   sequence s_sw_clean;
      !rst_req && !sw_req_in.soft_interrupt_instr;
   endsequence
   property p_reset_vec;
      rst_req |=> branch_out.valid && branch_out.vec == rais_pkg::VEC_RESET
                  && core_reset_out;
   endproperty
   a_reset_vec: assert property (p_reset_vec) else $error("reset branch"); // [RQ14]
   property p_rst_clear;
      rst_req |=> lmask == '0 && en == '0 && gflag && core_int_lines_out == '0;
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("reset state"); // [RQ2]
   property p_wdog;
      wdog_timeout_in |=> core_reset_out && pend == '0;
   endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog reset"); // [RQ3]
   property p_pin_a;
      ($rose(power_fault_irq_a_in) && !rst_req) |=> pend[rais_pkg::SRC_PFA];
   endproperty
   a_pin_a: assert property (p_pin_a) else $error("fault pin lost"); // [RQ4]
   property p_line_gate;
      core_int_lines_out[0] |-> $past(lmask[0]) && $past(|(pend & en & on_line(3'h0)));
   endproperty
   a_line_gate: assert property (p_line_gate) else $error("line gating"); // [RQ5]
   property p_soft_interrupt_instr;
      (sw_req_in.soft_interrupt_instr && !rst_req) |=> branch_out.vec == $past(sw_req_in.vec)
                                       && gflag && branch_out.gdis;
   endproperty
   a_soft_interrupt_instr: assert property (p_soft_interrupt_instr) else $error("soft interrupt"); // [RQ7]
   property p_nmi;
      (s_sw_clean and sw_req_in.nmi) |=> branch_out.vec == rais_pkg::VEC_NMI
                                          && gflag;
   endproperty
   a_nmi: assert property (p_nmi) else $error("nmi branch"); // [RQ8]
   property p_trap;
      (s_sw_clean and !sw_req_in.nmi && sw_req_in.trap) |=> branch_out.valid
         && !branch_out.gdis && (branch_out.vec == rais_pkg::VEC_TRAP
                                 || branch_out.vec == rais_pkg::VEC_EMU);
   endproperty
   a_trap: assert property (p_trap) else $error("trap branch"); // [RQ10]
   property p_ack;
      s_ack_taken |=> periph_vector_code_out == rais_pkg::SRC_CODE[$past(sel)]
                      && stat[rais_pkg::STAT_ACK];
   endproperty
   a_ack: assert property (p_ack) else $error("vector code"); // [RQ16]
endmodule // rais_ctrl
`default_nettype wire

// >>> dv/rais_core_model.sv
// Behavioural core model: acknowledges the lowest active core line on request.
// Assumes the controller lines run on the same clock as this model.
`default_nettype none
module rais_core_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [rais_pkg::NLINE-1:0] lines_in,
   input wire logic go_in,
   input wire logic [3:0] wait_in,
   output logic ack_out,
   output logic [2:0] ack_line_out,
   output logic done_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic busy;
   logic [3:0] cnt;
   logic [2:0] sel;
   // Line 0 is taken when no line is active, so an empty ack can be made
   always_comb begin
      sel = 3'h0;
      for (int k = rais_pkg::NLINE - 1; k >= 0; k--) begin
         if (lines_in[k]) begin
            sel = 3'(k);
         end
      end
   end
   // Wait count lets the bench answer promptly or slowly
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         busy <= 1'b0;
         cnt <= 4'h0;
         ack_out <= 1'b0;
         ack_line_out <= 3'h0;
         done_out <= 1'b0;
      end else begin
         ack_out <= 1'b0;
         done_out <= ack_out;
         if (go_in && !busy) begin
            busy <= 1'b1;
            cnt <= wait_in;
         end else if (busy && cnt == 4'h0) begin
            ack_out <= 1'b1;
            ack_line_out <= sel;
            busy <= 1'b0;
         end else if (busy) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule // rais_core_model
`default_nettype wire

// >>> dv/rais_ctrl_bench.sv
// Self-checking bench of the reset and interrupt controller.
// Assumes rais_pkg, rais_ctrl and rais_core_model are compiled first.
`default_nettype none
module rais_ctrl_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic pin_n = 1'b1, wdog = 1'b0, x1 = 1'b0, x2 = 1'b0, pfa = 1'b0, pfb = 1'b0;
   logic [rais_pkg::NSRC-1:0] preq = '0;
   rais_pkg::rais_sw_req_t sw = '0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0;
   logic wr = 1'b0, rd = 1'b0, go = 1'b0, ack, done;
   logic [3:0] wt = 4'h0;
   logic [2:0] ack_line;
   logic [15:0] rdata;
   logic core_rst, gflag, irq;
   logic [5:0] lines;
   rais_pkg::rais_branch_t br;
   logic [7:0] pvec;
   int failures = 0;
   int checks = 0;
   // Rows: soft request {soft_interrupt_instr,nmi,trap,emu,vec}, branch, flag after
   logic [9:0] req_tab [5] = '{10'h210, 10'h100, 10'h080, 10'h0c0, 10'h226};
   logic [7:0] br_tab [5] = '{8'hd0, 8'he4, 8'ha2, 8'ha6, 8'he6};
   logic gf_tab [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
   always #12.5 clk_in = ~clk_in;
   rais_ctrl dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reset_pin_n_in(pin_n),
      .wdog_timeout_in(wdog), .ext_irq_one_in(x1), .ext_irq_two_in(x2),
      .power_fault_irq_a_in(pfa), .power_fault_irq_b_in(pfb), .periph_req_in(preq),
      .core_ack_in(ack), .core_ack_line_in(ack_line), .sw_req_in(sw),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .core_reset_out(core_rst), .core_int_lines_out(lines),
      .branch_out(br), .global_int_disable_flag_out(gflag),
      .periph_vector_code_out(pvec), .irq_out(irq));
   rais_core_model core (.clk_in(clk_in), .rst_n_in(rst_n_in), .lines_in(lines),
      .go_in(go), .wait_in(wt), .ack_out(ack), .ack_line_out(ack_line),
      .done_out(done));
   task complete_run();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask
   task rd_chk(input string n, input logic [3:0] a, input logic [15:0] e);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1 chk(n, rdata, e);
   endtask
   task do_ack(input logic [3:0] w);
      @(posedge clk_in);
      go <= 1'b1;
      wt <= w;
      @(posedge clk_in);
      go <= 1'b0;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk_in);
         #1;
         if (done === 1'b1) break;
      end
      chk("ack done", 16'(done), 16'h1);
   endtask
   // Limit is well above the expected run of about 150 cycles
   initial begin
      #200000;
      failures++;
      complete_run();
   end
   initial begin
      repeat (2) @(posedge clk_in);
      #1 chk("core reset", 16'(core_rst), 16'h1);
      chk("branch", 16'(br), 16'h00c0);
      @(posedge clk_in);
      rst_n_in <= 1'b1;
      cyc(1);
      chk("core reset", 16'(core_rst), 16'h0);
      rd_chk("lmask", rais_pkg::ADDR_LMASK, 16'h0);
      rd_chk("gflag", rais_pkg::ADDR_GFLAG, 16'h1);
      rd_chk("en0", rais_pkg::ADDR_EN0, 16'h0);
      for (int i = 0; i < 5; i++) begin
         wr_reg(rais_pkg::ADDR_GFLAG, 16'h0);
         @(posedge clk_in);
         sw <= rais_pkg::rais_sw_req_t'(req_tab[i]);
         @(posedge clk_in);
         sw <= '0;
         #1 chk("branch", 16'(br), 16'(br_tab[i]));
         cyc(1);
         chk("branch valid", 16'(br.valid), 16'h0);
         chk("gflag", 16'(gflag), 16'(gf_tab[i]));
      end
      // Bit 0 of the peripheral bus belongs to a pin and must be ignored
      wr_reg(rais_pkg::ADDR_EN0, 16'h1200);
      @(posedge clk_in);
      preq <= 22'h002401;
      @(posedge clk_in);
      preq <= '0;
      cyc(2);
      chk("lines", 16'(lines), 16'h0);
      rd_chk("pend0", rais_pkg::ADDR_PEND0, 16'h1200);
      wr_reg(rais_pkg::ADDR_LMASK, 16'h2);
      cyc(2);
      chk("lines", 16'(lines), 16'h2);
      do_ack(4'h0);
      chk("pvec", 16'(pvec), 16'h21);
      rd_chk("pend0", rais_pkg::ADDR_PEND0, 16'h1000);
      do_ack(4'h5);
      chk("pvec", 16'(pvec), 16'h27);
      cyc(1);
      chk("lines", 16'(lines), 16'h0);
      rd_chk("stat", rais_pkg::ADDR_STAT, 16'h1);
      wr_reg(rais_pkg::ADDR_IMASK, 16'h1);
      cyc(2);
      chk("irq", 16'(irq), 16'h1);
      wr_reg(rais_pkg::ADDR_IMASK, 16'h2);
      cyc(2);
      chk("irq", 16'(irq), 16'h0);
      do_ack(4'h1);
      chk("pvec", 16'(pvec), 16'h0);
      cyc(2);
      chk("irq", 16'(irq), 16'h1);
      rd_chk("stat", rais_pkg::ADDR_STAT, 16'h3);
      wr_reg(rais_pkg::ADDR_STAT, 16'h3);
      cyc(2);
      chk("irq", 16'(irq), 16'h0);
      rd_chk("stat", rais_pkg::ADDR_STAT, 16'h0);
      // Pins: only the general pin one is enabled, so the higher fault loses
      wr_reg(rais_pkg::ADDR_EN0, 16'h0);
      @(posedge clk_in);
      {x1, x2, pfa, pfb} <= 4'hf;
      cyc(2);
      rd_chk("pend0", rais_pkg::ADDR_PEND0, 16'h000d);
      rd_chk("pend2", rais_pkg::ADDR_PEND2, 16'h0001);
      wr_reg(rais_pkg::ADDR_LMASK, 16'h1);
      cyc(2);
      chk("lines", 16'(lines), 16'h0);
      wr_reg(rais_pkg::ADDR_EN0, 16'h0004);
      cyc(2);
      chk("lines", 16'(lines), 16'h1);
      do_ack(4'h2);
      chk("pvec", 16'(pvec), 16'h01);
      rd_chk("pvec reg", rais_pkg::ADDR_PVEC, 16'h0001);
      @(posedge clk_in);
      {x1, x2, pfa, pfb} <= 4'h0;
      // Second fault pin sits in the upper word; enable it, then clear it by write
      wr_reg(rais_pkg::ADDR_EN2, 16'h0001);
      rd_chk("en2", rais_pkg::ADDR_EN2, 16'h0001);
      cyc(1);
      chk("lines", 16'(lines), 16'h1);
      wr_reg(rais_pkg::ADDR_PEND2, 16'h0001);
      cyc(2);
      chk("lines", 16'(lines), 16'h0);
      rd_chk("pend2", rais_pkg::ADDR_PEND2, 16'h0);
      wr_reg(rais_pkg::ADDR_PEND0, 16'hffff);
      rd_chk("pend0", rais_pkg::ADDR_PEND0, 16'h0);
      rd_chk("unmapped", 4'hf, 16'h0);
      for (int i = 0; i < 2; i++) begin
         wr_reg(rais_pkg::ADDR_LMASK, 16'h3f);
         @(posedge clk_in);
         if (i == 0) wdog <= 1'b1;
         else pin_n <= 1'b0;
         @(posedge clk_in);
         wdog <= 1'b0;
         pin_n <= 1'b1;
         #1 chk("core reset", 16'(core_rst), 16'h1);
         chk("branch", 16'(br), 16'h00c0);
         cyc(1);
         chk("core reset", 16'(core_rst), 16'h0);
         rd_chk("lmask", rais_pkg::ADDR_LMASK, 16'h0);
      end
      complete_run();
   end
endmodule // rais_ctrl_bench
`default_nettype wire
